// File: verilog/ecsc_pkg.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// shared constants of the configuration store controller
package ecsc_pkg;

    // widths of the register space and of one register
    localparam int unsigned REG_AW = 12;
    localparam int unsigned DW     = 8;

    // segment list window
    localparam int unsigned      SEG_COUNT      = 23;
    localparam int unsigned      SEG_IDX_W      = 5;
    localparam logic [REG_AW-1:0] SEG_FIRST_ADDR = 12'ha00;
    localparam logic [REG_AW-1:0] SEG_LAST_ADDR  = 12'ha16;

    // control and status register offsets
    localparam logic [REG_AW-1:0] STATUS_ADDR = 12'hb00;
    localparam logic [REG_AW-1:0] ERROR_ADDR  = 12'hb01;
    localparam logic [REG_AW-1:0] RELOAD_ADDR = 12'hb02;
    localparam logic [REG_AW-1:0] SAVE_ADDR   = 12'hb03;
    localparam logic [REG_AW-1:0] COMMIT_ADDR = 12'h232;

    // field positions
    localparam int unsigned BUSY_BIT   = 0;
    localparam int unsigned ERROR_BIT  = 0;
    localparam int unsigned WREN_BIT   = 0;
    localparam int unsigned RELOAD_BIT = 1;
    localparam int unsigned SAVE_BIT   = 0;
    localparam int unsigned COMMIT_BIT = 0;

    // reset values
    localparam logic WREN_RESET = 1'b0;

    // segment list encoding: bit 7 set marks an operation code,
    // otherwise the byte is (length - 1) followed by address high, address low
    localparam int unsigned OP_FLAG_BIT = 7;
    localparam logic [DW-1:0] OP_COMMIT = 8'h80;
    localparam logic [DW-1:0] OP_END    = 8'hff;

    // default list: 0x000..0x27f in five runs of 128, then commit, then end
    localparam logic [DW-1:0] SEG_DEFAULT [0:SEG_COUNT-1] = '{
        8'h7f, 8'h00, 8'h00,
        8'h7f, 8'h00, 8'h80,
        8'h7f, 8'h01, 8'h00,
        8'h7f, 8'h01, 8'h80,
        8'h7f, 8'h02, 8'h00,
        8'h80, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
    };

    // nonvolatile store address width (default depth 1024 bytes)
    localparam int unsigned STORE_AW_DEF = 10;

    // transfer sequencer states
    typedef enum logic [10:0] {
        S_IDLE   = 11'h001,
        S_FETCH  = 11'h002,
        S_ADDRH  = 11'h004,
        S_ADDRL  = 11'h008,
        S_XRD    = 11'h010,
        S_XWAIT  = 11'h020,
        S_XWR    = 11'h040,
        S_CHECK  = 11'h080,
        S_VWAIT  = 11'h100,
        S_VERIFY = 11'h200,
        S_DONE   = 11'h400
    } ecsc_state_e;

endpackage

`default_nettype wire

// File: verilog/ecsc_store_mem.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// byte array standing for the nonvolatile store, registered read data
module ecsc_store_mem
#(
    parameter int unsigned AW = 10,
    parameter int unsigned DW = 8
)
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // single access port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wrData,
    output logic      [DW-1:0] rdData
);

    logic [DW-1:0] cells [0:(1<<AW)-1];

    // write port, no reset on the array
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            cells[addr] <= wrData;
        end
    end

    // read data always come out of a register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rdData <= '0;
        end
        else
        begin
            rdData <= cells[addr];
        end
    end

endmodule

`default_nettype wire

// File: verilog/ecsc_ctrl.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - commit write copies buffer into active registers
// - commit bit clears itself after the copy
// - twenty-three segment registers hold addresses and lengths
// - list opcodes commit and end run in order
// - default list covers registers 0x000..0x27f, then commits
// - pending flag reads one during a transfer
// - status pin carries pending flag when selected
// - error flag reports bad data in transfers
// - reload bit with boot pin low reloads
// - reload bit clears on the next clock
// - write enable defaults off, protects the store
// - save trigger copies buffer bank into store
// - save trigger clears when the save finishes
module ecsc_ctrl
#(
    parameter int unsigned STORE_AW = ecsc_pkg::STORE_AW_DEF
)
(
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // register access from the serial control port
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    input  wire logic [ecsc_pkg::REG_AW-1:0]   regAddr,
    input  wire logic [ecsc_pkg::DW-1:0]       regWrData,
    output logic      [ecsc_pkg::DW-1:0]       regRdData,
    // pins
    input  wire logic                          storeBootPin,
    input  wire logic                          statusSelect,
    output logic                               statusPin,
    // buffer register bank
    output logic      [ecsc_pkg::REG_AW-1:0]   bufAddr,
    output logic                               bufWe,
    output logic      [ecsc_pkg::DW-1:0]       bufWrData,
    input  wire logic [ecsc_pkg::DW-1:0]       bufRdData,
    // device strobes
    output logic                               commitPulse,
    output logic                               softResetPulse
);
    import ecsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // true for an address inside the segment list window
    function automatic logic segHit(input logic [REG_AW-1:0] addr);
        segHit = (addr >= SEG_FIRST_ADDR) && (addr <= SEG_LAST_ADDR);
    endfunction

    // list index of a segment register address
    function automatic logic [SEG_IDX_W-1:0] segIndex(input logic [REG_AW-1:0] addr);
        logic [REG_AW-1:0] diff;
        diff = addr - SEG_FIRST_ADDR;
        segIndex = diff[SEG_IDX_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam logic [SEG_IDX_W-1:0] SEG_LIMIT = SEG_IDX_W'(SEG_COUNT);

    ecsc_state_e           state, next_state;
    logic [SEG_IDX_W-1:0]  segIdx, next_segIdx;
    logic [6:0]            count, next_count;
    logic [REG_AW-1:0]     xAddr, next_xAddr;
    logic [STORE_AW-1:0]   storePtr, next_storePtr;
    logic [DW-1:0]         sum, next_sum;
    logic                  saving, next_saving;
    logic                  xferError, next_xferError;
    logic [REG_AW-1:0]     next_bufAddr;
    logic                  next_bufWe;
    logic [DW-1:0]         next_bufWrData;
    logic [STORE_AW-1:0]   memAddr, next_memAddr;
    logic                  memWe, next_memWe;
    logic [DW-1:0]         memWrData, next_memWrData;
    logic [DW-1:0]         memRdData;

    logic [DW-1:0]         segList [0:SEG_COUNT-1];
    logic [DW-1:0]         next_segList [0:SEG_COUNT-1];
    logic                  wrEn, next_wrEn;
    logic                  saveBit, next_saveBit;
    logic                  next_softResetPulse;
    logic                  next_commitPulse;
    logic [DW-1:0]         next_regRdData;
    logic                  next_statusPin;

    logic                  bootSync1, bootSync2;
    logic                  busy;
    logic                  startSave;
    logic                  startLoad;
    logic                  listCommit;
    logic                  finish;
    logic [DW-1:0]         curSeg;
    logic [DW-1:0]         xData;

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile store array

    ecsc_store_mem
    #(
        .AW (STORE_AW),
        .DW (DW)
    )
    u_store
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .we      (memWe),
        .addr    (memAddr),
        .wrData  (memWrData),
        .rdData  (memRdData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // boot-select pin synchroniser, idles high (no reload)
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bootSync1 <= 1'b1;
            bootSync2 <= 1'b1;
        end
        else
        begin
            bootSync1 <= storeBootPin;
            bootSync2 <= bootSync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared status terms
    assign busy      = (state != S_IDLE);
    assign startSave = regWr && (regAddr == SAVE_ADDR)
                       && regWrData[SAVE_BIT] && !busy && !saveBit;
    assign startLoad = softResetPulse;
    assign curSeg    = (segIdx < SEG_LIMIT) ? segList[segIdx] : OP_END;
    assign xData     = saving ? bufRdData : memRdData;

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer: walks the segment list and moves bytes
    always_comb
    begin
        next_state     = state;
        next_segIdx    = segIdx;
        next_count     = count;
        next_xAddr     = xAddr;
        next_storePtr  = storePtr;
        next_sum       = sum;
        next_saving    = saving;
        next_xferError = xferError;
        next_bufAddr   = bufAddr;
        next_bufWe     = 1'b0;
        next_bufWrData = bufWrData;
        next_memAddr   = memAddr;
        next_memWe     = 1'b0;
        next_memWrData = memWrData;
        listCommit     = 1'b0;
        finish         = 1'b0;
        case (state)
            S_IDLE:
            begin
                next_segIdx   = '0;
                next_storePtr = '0;
                next_sum      = '0;
                if (startSave)
                begin
                    next_saving    = 1'b1;
                    next_xferError = !wrEn;
                    next_state     = wrEn ? S_FETCH : S_DONE;
                end
                else if (startLoad)
                begin
                    next_saving    = 1'b0;
                    next_xferError = 1'b0;
                    next_state     = S_FETCH;
                end
            end
            S_FETCH:
            begin
                if (curSeg == OP_END)
                begin
                    next_state = S_CHECK;
                end
                else if (curSeg == OP_COMMIT)
                begin
                    listCommit  = 1'b1;
                    next_segIdx = segIdx + 5'h1;
                end
                else if (curSeg[OP_FLAG_BIT])
                begin
                    next_xferError = 1'b1;                         // unknown opcode
                    next_state     = S_CHECK;
                end
                else
                begin
                    next_count  = curSeg[6:0];
                    next_segIdx = segIdx + 5'h1;
                    next_state  = S_ADDRH;
                end
            end
            S_ADDRH:
            begin
                next_xAddr[REG_AW-1:8] = curSeg[REG_AW-9:0];
                next_segIdx            = segIdx + 5'h1;
                next_state             = S_ADDRL;
            end
            S_ADDRL:
            begin
                next_xAddr[7:0] = curSeg;
                next_segIdx     = segIdx + 5'h1;
                next_state      = S_XRD;
            end
            S_XRD:
            begin
                if (&storePtr)
                begin
                    next_xferError = 1'b1;                         // store full
                    next_state     = S_CHECK;
                end
                else
                begin
                    next_bufAddr = xAddr;
                    next_memAddr = storePtr;
                    next_state   = S_XWAIT;
                end
            end
            S_XWAIT:
            begin
                next_state = S_XWR;                                // read data in flight
            end
            S_XWR:
            begin
                if (saving)
                begin
                    next_memWe     = wrEn;
                    next_memAddr   = storePtr;
                    next_memWrData = xData;
                    next_xferError = xferError || !wrEn;
                end
                else
                begin
                    next_bufWe     = 1'b1;
                    next_bufAddr   = xAddr;
                    next_bufWrData = xData;
                end
                next_sum      = sum ^ xData;
                next_storePtr = storePtr + 1'b1;
                next_xAddr    = xAddr + 1'b1;
                if (count == 7'h00)
                begin
                    next_state = S_FETCH;
                end
                else
                begin
                    next_count = count - 1'b1;
                    next_state = S_XRD;
                end
            end
            S_CHECK:
            begin
                next_memAddr = storePtr;
                if (saving)
                begin
                    next_memWe     = wrEn;                         // check byte closes a save
                    next_memWrData = sum;
                    next_state     = S_DONE;
                end
                else
                begin
                    next_state = S_VWAIT;
                end
            end
            S_VWAIT:
            begin
                next_state = S_VERIFY;
            end
            S_VERIFY:
            begin
                next_xferError = xferError || (memRdData != sum);
                next_state     = S_DONE;
            end
            S_DONE:
            begin
                finish     = 1'b1;
                next_state = S_IDLE;
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= S_IDLE;
            segIdx    <= '0;
            count     <= '0;
            xAddr     <= '0;
            storePtr  <= '0;
            sum       <= '0;
            saving    <= 1'b0;
            xferError <= 1'b0;
            bufAddr   <= '0;
            bufWe     <= 1'b0;
            bufWrData <= '0;
            memAddr   <= '0;
            memWe     <= 1'b0;
            memWrData <= '0;
        end
        else
        begin
            state     <= next_state;
            segIdx    <= next_segIdx;
            count     <= next_count;
            xAddr     <= next_xAddr;
            storePtr  <= next_storePtr;
            sum       <= next_sum;
            saving    <= next_saving;
            xferError <= next_xferError;
            bufAddr   <= next_bufAddr;
            bufWe     <= next_bufWe;
            bufWrData <= next_bufWrData;
            memAddr   <= next_memAddr;
            memWe     <= next_memWe;
            memWrData <= next_memWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file: segment list, control bits, read mux, status pin
    always_comb
    begin
        next_segList = segList;
        next_wrEn    = wrEn;
        next_saveBit = saveBit;
        // segment list is frozen while a transfer runs
        if (regWr && segHit(regAddr) && !busy)
        begin
            next_segList[segIndex(regAddr)] = regWrData;
        end
        if (regWr && (regAddr == RELOAD_ADDR))
        begin
            next_wrEn = regWrData[WREN_BIT];
        end
        // set by the trigger, held until the sequencer finishes
        if (startSave)
        begin
            next_saveBit = 1'b1;
        end
        else if (finish && saving)
        begin
            next_saveBit = 1'b0;
        end
        // one-cycle strobe, reads back 1 only in the cycle after the write
        next_softResetPulse = regWr && (regAddr == RELOAD_ADDR)
                              && regWrData[RELOAD_BIT]
                              && !bootSync2 && !busy;
        next_commitPulse = listCommit
                           || (regWr && (regAddr == COMMIT_ADDR)
                               && regWrData[COMMIT_BIT]);
        next_statusPin = statusSelect && busy;
        next_regRdData = regRdData;
        if (regRd)
        begin
            next_regRdData = '0;                                   // unmapped reads 0
            if (segHit(regAddr))
            begin
                next_regRdData = segList[segIndex(regAddr)];
            end
            else
            begin
                case (regAddr)
                    STATUS_ADDR: next_regRdData[BUSY_BIT]  = busy;
                    ERROR_ADDR:  next_regRdData[ERROR_BIT] = xferError;
                    RELOAD_ADDR:
                    begin
                        next_regRdData[WREN_BIT]   = wrEn;
                        next_regRdData[RELOAD_BIT] = softResetPulse;
                    end
                    SAVE_ADDR:   next_regRdData[SAVE_BIT]   = saveBit;
                    COMMIT_ADDR: next_regRdData[COMMIT_BIT] = commitPulse;
                    default:     next_regRdData = '0;
                endcase
            end
        end
    end

    // register file registers, list takes its default on reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            segList        <= SEG_DEFAULT;
            wrEn           <= WREN_RESET;
            saveBit        <= 1'b0;
            softResetPulse <= 1'b0;
            commitPulse    <= 1'b0;
            regRdData      <= '0;
            statusPin      <= 1'b0;
        end
        else
        begin
            segList        <= next_segList;
            wrEn           <= next_wrEn;
            saveBit        <= next_saveBit;
            softResetPulse <= next_softResetPulse;
            commitPulse    <= next_commitPulse;
            regRdData      <= next_regRdData;
            statusPin      <= next_statusPin;
        end
    end

endmodule

`default_nettype wire

// File: tb/ecsc_bank_model.sv
`default_nettype none
////////////////////////////////////////
// buffer register bank, registered read
module ecsc_bank_model
(
    // clock
    input  wire logic        sys_clk,
    // bank port
    input  wire logic [11:0] addr,
    input  wire logic        we,
    input  wire logic [7:0]  wrData,
    output logic      [7:0]  rdData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:4095];
    // loads land here; read data follows the address one edge late
    // plain always: the bench seeds mem by hierarchical writes
    always @(posedge sys_clk)
    begin
        if (we)
            mem[addr] <= wrData;
        rdData <= mem[addr];
    end
endmodule
`default_nettype wire

// File: tb/ecsc_ctrl_monitor.sv
`default_nettype none
////////////////////////////////////////
// port checker of the store controller
module ecsc_ctrl_monitor
#(
    parameter int unsigned STORE_AW = 10
)
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // register port
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [11:0] regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic [7:0]  regRdData,
    // pins
    input wire logic        storeBootPin,
    input wire logic        statusSelect,
    input wire logic        statusPin,
    // bank and strobes
    input wire logic [11:0] bufAddr,
    input wire logic        bufWe,
    input wire logic [7:0]  bufWrData,
    input wire logic [7:0]  bufRdData,
    input wire logic        commitPulse,
    input wire logic        softResetPulse
);
    import ecsc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic cWr;
    logic rWr;
    // decoded strobe writes
    assign cWr = regWr && regAddr == COMMIT_ADDR && regWrData[0];
    assign rWr = regWr && regAddr == RELOAD_ADDR && regWrData[1];
    a_commit_after_write: assert property (cWr |=> commitPulse)
        else $error("commit pulse missing after commit write");
    a_commit_one_cycle: assert property (commitPulse && !cWr |=> !commitPulse)
        else $error("commit pulse longer than one cycle");
    a_status_pin_select: assert property (!$past(statusSelect) |-> !statusPin)
        else $error("status pin high while not selected");
    a_reload_boot_high: assert property (rWr && storeBootPin && $past(storeBootPin)
        && $past(storeBootPin, 2) |=> !softResetPulse)
        else $error("reload taken with boot pin high");
    a_reload_cause: assert property ($rose(softResetPulse) |-> $past(rWr))
        else $error("soft reset without reload write");
    a_reload_one_cycle: assert property (softResetPulse |=> !softResetPulse)
        else $error("soft reset pulse longer than one cycle");
    a_load_one_pulse: assert property (bufWe |=> !bufWe)
        else $error("bank write pulse longer than one cycle");
    a_status_reserved: assert property (regRd && regAddr == STATUS_ADDR
        |=> regRdData[7:1] == 7'h00)
        else $error("pending register reserved bits set");
    a_error_reserved: assert property (regRd && regAddr == ERROR_ADDR
        |=> regRdData[7:1] == 7'h00)
        else $error("error register reserved bits set");
    c_commit: cover property (commitPulse);
    c_reload: cover property (softResetPulse);
    c_load: cover property (bufWe);
endmodule
bind ecsc_ctrl ecsc_ctrl_monitor #(.STORE_AW(STORE_AW)) ecsc_ctrl_monitor_i (.sys_clk, .rst,
    .regWr, .regRd, .regAddr, .regWrData, .regRdData, .storeBootPin, .statusSelect,
    .statusPin, .bufAddr, .bufWe, .bufWrData, .bufRdData, .commitPulse, .softResetPulse);
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
////////////////////////////////////////
// bench of the store controller
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ecsc_pkg::*;
    logic        sys_clk = 0, rst = 1, regWr = 0, regRd = 0, boot = 0, sel = 1;
    logic        statusPin, bufWe, commitPulse, softResetPulse, rdTaken = 0;
    logic [11:0] regAddr = '0, bufAddr;
    logic [7:0]  wrD = '0, rdD, bufWrData, bufRdData, orig [0:2];
    logic [7:0]  expQ [$];
    logic [7:0]  lst [0:4] = '{8'h02, 8'h00, 8'h10, OP_COMMIT, OP_END};
    logic [31:0] seed = 32'h36958db6;
    int          n_mismatch = 0, comparisons = 0, cyc = 0, nCommit = 0;
    ecsc_ctrl #(.STORE_AW(6)) ecsc_ctrl_i (.sys_clk, .rst, .regWr, .regRd, .regAddr,
        .regWrData(wrD), .regRdData(rdD), .storeBootPin(boot), .statusSelect(sel),
        .statusPin, .bufAddr, .bufWe, .bufWrData, .bufRdData, .commitPulse,
        .softResetPulse);
    ecsc_bank_model ecsc_bank_model_i (.sys_clk, .addr(bufAddr), .we(bufWe),
        .wrData(bufWrData), .rdData(bufRdData));
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop();
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one write or read per call, held from falling edge to falling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regWr = 1;
        regAddr = a;
        wrD = d;
        @(negedge sys_clk);
        regWr = 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        regRd = 1;
        regAddr = a;
        expQ.push_back(e);
        @(negedge sys_clk);
        regRd = 0;
    endtask
    // wait for the transfer to end, bounded
    task automatic idle(input logic busy);
        repeat (3) @(negedge sys_clk);
        cmp({7'h00, statusPin}, {7'h00, busy});
        for (int i = 0; i < 2000 && statusPin !== 1'b0; i++)
            @(negedge sys_clk);
        cmp({7'h00, statusPin}, 8'h00);
    endtask
    // read results are compared with the oldest note
    always @(posedge sys_clk)
    begin
        rdTaken <= regRd;
        cyc++;
        if (commitPulse === 1'b1)
            nCommit++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    always @(negedge sys_clk)
        if (rdTaken)
            cmp(rdD, expQ.pop_front());
    ////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 4096; i++)
        begin
            seed = lfsr(seed);
            ecsc_bank_model_i.mem[i] = seed[7:0];
        end
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 0;
        // reset values, default list, unmapped place
        rd(SEG_FIRST_ADDR, 8'h7f);
        rd(12'ha0f, OP_COMMIT);
        rd(SEG_LAST_ADDR, OP_END);
        rd(STATUS_ADDR, 8'h00);
        rd(RELOAD_ADDR, 8'h00);
        rd(12'hc00, 8'h00);
        // commit strobe self-clears
        wr(COMMIT_ADDR, 8'h01);
        rd(COMMIT_ADDR, 8'h00);
        cmp(nCommit[7:0], 8'h01);
        // short list: three bytes from 0x010, commit, end
        foreach (lst[i])
            wr(SEG_FIRST_ADDR + 12'(i), lst[i]);
        rd(12'ha03, OP_COMMIT);
        for (int i = 0; i < 3; i++)
            orig[i] = ecsc_bank_model_i.mem[16 + i];
        // save refused while protected
        wr(SAVE_ADDR, 8'h01);
        idle(1'b0);
        rd(ERROR_ADDR, 8'h01);
        rd(SAVE_ADDR, 8'h00);
        // save with writes enabled
        wr(RELOAD_ADDR, 8'h01);
        nCommit = 0;
        wr(SAVE_ADDR, 8'h01);
        rd(SAVE_ADDR, 8'h01);
        rd(STATUS_ADDR, 8'h01);
        // status pin stays low while its select is off
        sel = 0;
        repeat (2) @(negedge sys_clk);
        cmp({7'h00, statusPin}, 8'h00);
        sel = 1;
        idle(1'b1);
        rd(STATUS_ADDR, 8'h00);
        rd(SAVE_ADDR, 8'h00);
        rd(ERROR_ADDR, 8'h00);
        cmp(nCommit[7:0], 8'h01);
        // corrupt the bank, reload refused with boot pin high
        for (int i = 0; i < 3; i++)
            ecsc_bank_model_i.mem[16 + i] = ~orig[i];
        boot = 1;
        repeat (3) @(negedge sys_clk);
        wr(RELOAD_ADDR, 8'h03);
        idle(1'b0);
        cmp(ecsc_bank_model_i.mem[16], ~orig[0]);
        // reload from the store restores the bank
        boot = 0;
        repeat (3) @(negedge sys_clk);
        wr(RELOAD_ADDR, 8'h03);
        idle(1'b1);
        for (int i = 0; i < 3; i++)
            cmp(ecsc_bank_model_i.mem[16 + i], orig[i]);
        rd(ERROR_ADDR, 8'h00);
        rd(RELOAD_ADDR, 8'h01);
        // bad list code during a reload raises the error flag
        wr(SEG_FIRST_ADDR, 8'h81);
        wr(RELOAD_ADDR, 8'h03);
        idle(1'b1);
        rd(ERROR_ADDR, 8'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
